/* File: hw/lpmc_pkg.sv */
// constants and types shared by the low power mode controller
package lpmc_pkg;
    localparam int unsigned LPMC_ADDR_W = 10;
    localparam int unsigned LPMC_NIB_W = 4;
    localparam logic [LPMC_ADDR_W-1:0] LPMC_IRQ_NIBBLE_ADDR = 10'h003;
    localparam logic [LPMC_ADDR_W-1:0] LPMC_RAM_VALID_ADDR = 10'h021;
    localparam int unsigned LPMC_CONV_FLAG_BIT = 0;
    localparam int unsigned LPMC_CONV_MASK_BIT = 1;
    localparam int unsigned LPMC_SER_FLAG_BIT = 2;
    localparam int unsigned LPMC_SER_MASK_BIT = 3;
    localparam int unsigned LPMC_RAM_VALID_BIT = 3;
    localparam logic LPMC_FLAG_RESET = 1'h0;
    localparam logic LPMC_MASK_RESET = 1'h1;
    localparam logic LPMC_RAM_VALID_RESET = 1'h0;
    localparam logic [LPMC_NIB_W-1:0] LPMC_NIB_ZERO = 4'h0;

    typedef enum logic [1:0] {
        LPMC_ACTIVE = 2'h0,
        LPMC_STANDBY = 2'h1,
        LPMC_STOP = 2'h3,
        LPMC_RESTART = 2'h2
    } lpmc_mode_t;

    typedef struct packed {
        lpmc_mode_t mode;
        logic serialRequestFlag;
        logic serialRequestMask;
        logic conversionDoneFlag;
        logic conversionRequestMask;
        logic ramValidFlag;
        logic wakeSync1_b;
        logic wakeSync2_b;
        logic wakeSeen;
        logic programRestart;
        logic instructionAsNop;
        logic [LPMC_NIB_W-1:0] readData;
    } lpmc_state_t;
endpackage

/* File: hw/low_power_mode_controller.sv */
// operating mode control with serial and converter request flags and masks
`timescale 1ns/10ps

module low_power_mode_controller (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic wakeFromHaltInput_b,
    input wire logic [lpmc_pkg::LPMC_ADDR_W-1:0] ctrlAddr,
    input wire logic ctrlWrite,
    input wire logic ctrlRead,
    input wire logic [lpmc_pkg::LPMC_NIB_W-1:0] ctrlWrData,
    output logic [lpmc_pkg::LPMC_NIB_W-1:0] ctrlRdData,
    input wire logic idleEntryInstruction,
    input wire logic haltEntryInstruction,
    input wire logic globalInterruptEnable,
    input wire logic otherRequestPending,
    input wire logic serialTransferDone,
    input wire logic serialTransferSuspended,
    input wire logic conversionDone,
    output logic instructionClockRun,
    output logic oscillatorRun,
    output logic cpuResetHold,
    output logic peripheralResetHold,
    output logic portOutputHold,
    output logic portHighImpedance,
    output logic programRestart,
    output logic instructionAsNop,
    output logic serialRequest,
    output logic conversionRequest,
    output logic interruptService,
    output logic [1:0] operatingMode
);
    import lpmc_pkg::*;

    logic rstSync1_b;
    logic rstSync2_b;
    lpmc_state_t state_q;
    lpmc_state_t state_d;
    logic anyRequest;
    logic enterIdle;
    logic enterHalt;
    logic wrIrqNibble;

    // reset release through two flip-flops; assertion stays asynchronous
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync1_b <= 1'h0;
            rstSync2_b <= 1'h0;
        end else begin
            rstSync1_b <= 1'h1;
            rstSync2_b <= rstSync1_b;
        end
    end

    always_comb begin
        serialRequest = state_q.serialRequestFlag & ~state_q.serialRequestMask;
        conversionRequest = state_q.conversionDoneFlag & ~state_q.conversionRequestMask;
        anyRequest = serialRequest | conversionRequest | otherRequestPending;
        interruptService = anyRequest & globalInterruptEnable & (state_q.mode == LPMC_ACTIVE);
        // entry is dropped to a no-op when a request would be lost otherwise
        enterIdle = idleEntryInstruction & ~(anyRequest & ~globalInterruptEnable);
        enterHalt = haltEntryInstruction & ~idleEntryInstruction
            & ~(anyRequest & ~globalInterruptEnable);
        wrIrqNibble = ctrlWrite & (ctrlAddr == LPMC_IRQ_NIBBLE_ADDR);
    end

    always_comb begin
        state_d = state_q;
        state_d.wakeSync1_b = wakeFromHaltInput_b;
        state_d.wakeSync2_b = state_q.wakeSync1_b;
        state_d.programRestart = 1'h0;
        state_d.instructionAsNop = 1'h0;

        // software may only clear a request flag; writing one leaves it alone
        if (wrIrqNibble) begin
            state_d.conversionDoneFlag = state_q.conversionDoneFlag
                & ctrlWrData[LPMC_CONV_FLAG_BIT];
            state_d.serialRequestFlag = state_q.serialRequestFlag
                & ctrlWrData[LPMC_SER_FLAG_BIT];
            state_d.conversionRequestMask = ctrlWrData[LPMC_CONV_MASK_BIT];
            state_d.serialRequestMask = ctrlWrData[LPMC_SER_MASK_BIT];
        end
        // hardware set wins over a clear in the same cycle
        if (conversionDone) begin
            state_d.conversionDoneFlag = 1'h1;
        end
        if (serialTransferDone | serialTransferSuspended) begin
            state_d.serialRequestFlag = 1'h1;
        end

        if (ctrlRead) begin
            if (ctrlAddr == LPMC_IRQ_NIBBLE_ADDR) begin
                state_d.readData = LPMC_NIB_ZERO;
                state_d.readData[LPMC_CONV_FLAG_BIT] = state_q.conversionDoneFlag;
                state_d.readData[LPMC_CONV_MASK_BIT] = state_q.conversionRequestMask;
                state_d.readData[LPMC_SER_FLAG_BIT] = state_q.serialRequestFlag;
                state_d.readData[LPMC_SER_MASK_BIT] = state_q.serialRequestMask;
            end else if (ctrlAddr == LPMC_RAM_VALID_ADDR) begin
                state_d.readData = LPMC_NIB_ZERO;
                state_d.readData[LPMC_RAM_VALID_BIT] = state_q.ramValidFlag;
            end else begin
                state_d.readData = LPMC_NIB_ZERO;
            end
        end

        case (state_q.mode)
            LPMC_ACTIVE: begin
                state_d.wakeSeen = 1'h0;
                if ((idleEntryInstruction | haltEntryInstruction) & ~enterIdle & ~enterHalt) begin
                    state_d.instructionAsNop = 1'h1;
                end
                if (enterIdle) begin
                    state_d.mode = LPMC_STANDBY;
                end else if (enterHalt) begin
                    state_d.mode = LPMC_STOP;
                end
            end
            LPMC_STANDBY: begin
                // wake on any unmasked request; the enable is checked after resuming
                if (anyRequest) begin
                    state_d.mode = LPMC_ACTIVE;
                end
            end
            LPMC_STOP: begin
                // the wake input restarts the oscillator while it is held low
                if (!state_q.wakeSync2_b) begin
                    state_d.wakeSeen = 1'h1;
                    state_d.mode = LPMC_RESTART;
                end
            end
            LPMC_RESTART: begin
                // release of the wake input ends stop; RAM is untouched
                if (state_q.wakeSync2_b) begin
                    state_d.mode = LPMC_ACTIVE;
                    state_d.ramValidFlag = 1'h1;
                    state_d.programRestart = 1'h1;
                end
            end
            default: begin
                state_d.mode = LPMC_ACTIVE;
            end
        endcase

        // stop resets every peripheral, including their request flags
        if (state_q.mode == LPMC_STOP || state_q.mode == LPMC_RESTART) begin
            state_d.serialRequestFlag = LPMC_FLAG_RESET;
            state_d.conversionDoneFlag = LPMC_FLAG_RESET;
            state_d.serialRequestMask = LPMC_MASK_RESET;
            state_d.conversionRequestMask = LPMC_MASK_RESET;
        end
    end

    always_ff @(posedge core_clk or negedge rstSync2_b) begin
        if (!rstSync2_b) begin
            state_q.mode <= LPMC_ACTIVE;
            state_q.serialRequestFlag <= LPMC_FLAG_RESET;
            state_q.serialRequestMask <= LPMC_MASK_RESET;
            state_q.conversionDoneFlag <= LPMC_FLAG_RESET;
            state_q.conversionRequestMask <= LPMC_MASK_RESET;
            state_q.ramValidFlag <= LPMC_RAM_VALID_RESET;
            state_q.wakeSync1_b <= 1'h1;
            state_q.wakeSync2_b <= 1'h1;
            state_q.wakeSeen <= 1'h0;
            state_q.programRestart <= 1'h1;
            state_q.instructionAsNop <= 1'h0;
            state_q.readData <= LPMC_NIB_ZERO;
        end else begin
            state_q <= state_d;
        end
    end

    always_comb begin
        ctrlRdData = state_q.readData;
        instructionClockRun = (state_q.mode == LPMC_ACTIVE) & rstSync2_b;
        oscillatorRun = (state_q.mode != LPMC_STOP);
        cpuResetHold = (state_q.mode == LPMC_STOP) | (state_q.mode == LPMC_RESTART);
        peripheralResetHold = (state_q.mode == LPMC_STOP)
            | (state_q.mode == LPMC_RESTART);
        portOutputHold = (state_q.mode == LPMC_STANDBY);
        portHighImpedance = (state_q.mode == LPMC_STOP) | (state_q.mode == LPMC_RESTART);
        programRestart = state_q.programRestart;
        instructionAsNop = state_q.instructionAsNop;
        operatingMode = state_q.mode;
    end
endmodule

/* File: bench/lpmc_wake_model.sv */
// wake pin model: low for the settling span once asked, pulled high otherwise
`timescale 1ns/10ps
module lpmc_wake_model #(parameter int SETTLE = 8) (
    input wire logic core_clk,
    input wire logic wakeGo,
    output logic wakeFromHaltInput_b
);
    int cnt = 0;
    always @(posedge core_clk)
        cnt <= wakeGo ? SETTLE : (cnt > 0 ? cnt - 1 : 0);
    assign wakeFromHaltInput_b = (cnt == 0);
endmodule

/* File: bench/lpmc_sva.sv */
// port assertions for the low power mode controller
`timescale 1ns/10ps
module lpmc_sva (
    input wire logic core_clk, rst_b, ctrlWrite, ctrlRead, idleEntryInstruction,
    input wire logic globalInterruptEnable, otherRequestPending, conversionDone,
    input wire logic instructionClockRun, oscillatorRun, programRestart, instructionAsNop,
    input wire logic serialRequest, conversionRequest,
    input wire logic [9:0] ctrlAddr,
    input wire logic [3:0] ctrlRdData,
    input wire logic [1:0] operatingMode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire logic anyReq = serialRequest || conversionRequest || otherRequestPending;
    sequence s_rd; ctrlRead && ctrlAddr == 10'h003; endsequence
    sequence s_cnv; conversionDone && !operatingMode[1] && !programRestart; endsequence
    a_ser_gate: assert property (s_rd |=>
        $past(serialRequest) == (ctrlRdData[2] && !ctrlRdData[3])) else $error("serial gate");
    a_conv_gate: assert property (s_rd |=>
        $past(conversionRequest) == (ctrlRdData[0] && !ctrlRdData[1])) else $error("conv gate");
    a_conv_set: assert property (s_cnv ##1 (!ctrlWrite && !operatingMode[1]) ##1 s_rd
        |=> ctrlRdData[0]) else $error("conversion flag not set");
    a_entry_nop: assert property (idleEntryInstruction && operatingMode == 2'h0
        && !programRestart && anyReq && !globalInterruptEnable
        |=> instructionAsNop && operatingMode == 2'h0) else $error("entry not cancelled");
    a_idle_clock: assert property (operatingMode == 2'h1 |-> !instructionClockRun
        && oscillatorRun && ($past(operatingMode) == 2'h1 || $past(idleEntryInstruction)))
        else $error("standby clocks wrong");
    a_req_wake: assert property (operatingMode == 2'h1 && anyReq
        |=> operatingMode == 2'h0) else $error("standby not left");
    a_wake_gate: assert property (!operatingMode[1] |=> operatingMode != 2'h2)
        else $error("wake acted outside stop");
    a_stop_exit: assert property (operatingMode == 2'h0 && $past(operatingMode) == 2'h2
        |-> programRestart) else $error("no restart at stop exit");
endmodule
bind low_power_mode_controller lpmc_sva chk_u (.*);

/* File: bench/low_power_mode_controller_tb.sv */
// self-checking bench for the low power mode controller
`timescale 1ns/10ps
module low_power_mode_controller_tb;
    logic core_clk = 1'h0, rst_b = 1'h0, ctrlWrite = 1'h0, ctrlRead = 1'h0;
    logic globalInterruptEnable = 1'h0, otherRequestPending = 1'h0;
    logic [9:0] ctrlAddr = 10'h0;
    logic [3:0] ctrlWrData = 4'h0, nib = 4'ha;
    logic [5:0] ev = 6'h0;
    wire logic idleEntryInstruction, haltEntryInstruction, serialTransferDone, conversionDone;
    wire logic serialTransferSuspended, wakeGo, wakeFromHaltInput_b, instructionClockRun;
    wire logic oscillatorRun, portOutputHold, programRestart, instructionAsNop;
    wire logic serialRequest, conversionRequest, interruptService;
    wire logic cpuResetHold, peripheralResetHold, portHighImpedance;
    wire logic [3:0] ctrlRdData;
    wire logic [1:0] operatingMode;
    int err_count = 0, checks_done = 0;
    assign {serialTransferSuspended, wakeGo, conversionDone} = ev[5:3];
    assign {serialTransferDone, haltEntryInstruction, idleEntryInstruction} = ev[2:0];
    always #12.5 core_clk = ~core_clk;
    low_power_mode_controller dut_u (.*);
    lpmc_wake_model wake_u (.*);
    task automatic chk(logic [3:0] seen, logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic acc(logic w, logic [9:0] a, logic [3:0] v);
        @(posedge core_clk);
        ctrlAddr <= a;
        ctrlWrData <= v;
        {ctrlWrite, ctrlRead} <= {w, !w};
        @(posedge core_clk);
        {ctrlWrite, ctrlRead} <= 2'h0;
        #1;
        if (!w)
            chk(ctrlRdData, v);
        else if (a == 10'h003)
            nib = {v[3], nib[2] & v[2], v[1], nib[0] & v[0]};
    endtask
    // pulse event inputs, then wait a bounded time for the expected mode
    task automatic go(logic [5:0] b, logic [1:0] m);
        int n = 0;
        @(posedge core_clk);
        ev <= b;
        @(posedge core_clk);
        ev <= 6'h0;
        #1;
        while (operatingMode !== m && n < 60) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk({2'h0, operatingMode}, {2'h0, m});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #20us err_count++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'h38b8dcfd));
        repeat (5) @(posedge core_clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge core_clk);
        acc(1'h0, 10'h003, 4'ha);
        acc(1'h1, 10'h021, 4'hf);
        acc(1'h0, 10'h021, 4'h0);
        acc(1'h0, 10'h3ff, 4'h0);
        repeat (6) begin
            acc(1'h1, 10'h003, 4'($urandom));
            acc(1'h0, 10'h003, nib);
        end
        acc(1'h1, 10'h003, 4'h0);
        go(6'h04, 2'h0);
        acc(1'h0, 10'h003, 4'h4);
        go(6'h28, 2'h0);
        acc(1'h0, 10'h003, 4'h5);
        chk({3'h0, serialRequest}, 4'h1);
        go(6'h01, 2'h0);
        chk({3'h0, instructionAsNop}, 4'h1);
        go(6'h02, 2'h0);
        chk({3'h0, instructionAsNop}, 4'h1);
        @(posedge core_clk);
        globalInterruptEnable <= 1'h1;
        #1 chk({3'h0, interruptService}, 4'h1);
        @(posedge core_clk);
        globalInterruptEnable <= 1'h0;
        acc(1'h1, 10'h003, 4'h0);
        go(6'h01, 2'h1);
        chk({operatingMode, instructionClockRun, portOutputHold}, 4'h5);
        chk({cpuResetHold, peripheralResetHold, portHighImpedance, oscillatorRun}, 4'h1);
        go(6'h10, 2'h1);
        repeat (6) go(6'h00, 2'h1);
        go(6'h08, 2'h0);
        acc(1'h0, 10'h003, 4'h1);
        acc(1'h1, 10'h003, 4'h0);
        go(6'h02, 2'h3);
        chk({operatingMode, oscillatorRun, instructionClockRun}, 4'hc);
        chk({cpuResetHold, peripheralResetHold, portHighImpedance, portOutputHold}, 4'he);
        go(6'h10, 2'h0);
        acc(1'h0, 10'h021, 4'h8);
        acc(1'h0, 10'h003, 4'ha);
        go(6'h01, 2'h1);
        @(posedge core_clk);
        rst_b <= 1'h0;
        #1 chk({operatingMode, instructionClockRun, programRestart}, 4'h1);
        repeat (5) @(posedge core_clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge core_clk);
        acc(1'h0, 10'h021, 4'h0);
        report_and_stop;
    end
endmodule
